//--- hw/servo_limit.sv
// Servo torque limit selection and absolute position supervision
//
// Local design decisions: the APB interface to the registers and the register addresses.
module servo_limit
  import servo_limit_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        data_select_low,
  input  wire logic        data_select_high,
  input  wire logic        torque_limit_enable,
  input  wire logic [15:0] analog_in_mv,
  input  wire logic [8:0]  torque_demand_pct,
  input  wire logic        pulse_step,
  input  wire logic        pulse_dir_neg,
  input  wire logic [15:0] pulses_per_rev,
  input  wire logic        battery_present,
  input  wire logic        battery_low,
  input  wire logic        encoder_connected,
  input  wire logic        retained_valid,
  input  wire logic [31:0] retained_pos,
  input  wire logic        absolute_function_switch,
  input  wire logic        motor_run_request,
  output logic      [8:0]  torque_cmd_pct,
  output logic      [8:0]  active_limit_pct,
  output logic             limit_reached_flag,
  output logic      [31:0] command_pos,
  output logic             position_retain_en,
  output logic             absolute_enabled,
  output logic      [alarm_width-1:0] alarm_flags
);
  typedef enum logic [1:0] {
    boot_capture = 2'b00,
    boot_check   = 2'b01,
    boot_run     = 2'b10
  } boot_type;

  boot_type    boot_r;
  logic        analog_input_option_r;
  logic        abs_en_r;
  logic        cfg_analog_r = analog_reset;
  logic        auto_offset_enable_r;
  logic [8:0]  analog_limit_gain_r;
  logic [15:0] analog_limit_offset_volts_r;
  logic [15:0] auto_offset_mv_r;
  logic [8:0]  entry_val [4];
  logic [3:0]  entry_wr;
  logic [1:0]  sel_r;
  logic        limit_en_r;
  logic [8:0]  limit_nxt;
  logic [8:0]  limit_r;
  logic [8:0]  analog_pct;
  logic [15:0] offset_mv;
  logic [15:0] net_mv;
  logic [31:0] analog_prod;
  logic [31:0] pos_r;
  logic [31:0] rev_r;
  logic [15:0] rev_frac_r;
  logic [31:0] boot_rev;
  logic [31:0] boot_frac;
  logic        range_err_r;
  logic [alarm_width-1:0] alarm_r;
  logic [alarm_width-1:0] alarm_set;
  logic        wr_acc;
  logic [31:0] wdata_lim;

  // Zero wait states: every register answers in the first access cycle
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign wdata_lim = pwdata;

  // Unmapped addresses answer with an error on the access phase
  always_comb begin
    case (paddr)
      addr_ctrl, addr_gain, addr_offset, addr_entry1, addr_entry2, addr_entry3,
      addr_entry0, addr_cfg_next, addr_status, addr_alarm, addr_alarm_clr,
      addr_cmd_pos, addr_limit: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  // Power-up: analog option latched once from its pending value, absolute enable from absolute_function_switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_r                <= boot_capture;
      analog_input_option_r <= analog_reset;
      abs_en_r              <= abs_reset;
    end else begin
      case (boot_r)
        boot_capture: begin
          analog_input_option_r <= cfg_analog_r;
          abs_en_r              <= absolute_function_switch;
          boot_r                <= boot_check;
        end
        boot_check: boot_r <= boot_run;
        boot_run:   boot_r <= boot_run;
        default:    boot_r <= boot_capture;
      endcase
    end
  end

  // Software settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_offset_enable_r        <= 1'b0;
      analog_limit_gain_r         <= gain_reset_pct;
      analog_limit_offset_volts_r <= offset_reset_mv;
    end else if (wr_acc) begin
      case (paddr)
        addr_ctrl:     auto_offset_enable_r <= wdata_lim[ctrl_auto_offset_bit];
        addr_gain:     analog_limit_gain_r  <= (wdata_lim[8:0] > gain_max_pct) ?
                                               gain_max_pct : wdata_lim[8:0];
        addr_offset:   analog_limit_offset_volts_r <= wdata_lim[15:0];
        default: ;
      endcase
    end
  end

  // Pending system setting stands for a non-volatile store: reset leaves it alone,
  // so a value written before a power cycle is the one the next boot latches
  always_ff @(posedge pclk) begin
    if (wr_acc && paddr == addr_cfg_next) begin
      cfg_analog_r <= wdata_lim[cfg_analog_bit];
    end
  end

  // Auto offset: software strobes capture while 0 V is applied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_offset_mv_r <= 16'h0000;
    end else if (wr_acc && paddr == addr_ctrl && wdata_lim[ctrl_capture_bit]) begin
      auto_offset_mv_r <= analog_in_mv;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_entry
      torque_entry_reg u_entry (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (entry_wr[gi]),
        .wr_data (wdata_lim[8:0]),
        .value_r (entry_val[gi])
      );
    end
  endgenerate

  // One write strobe per entry
  assign entry_wr[0] = wr_acc && paddr == addr_entry0;
  assign entry_wr[1] = wr_acc && paddr == addr_entry1;
  assign entry_wr[2] = wr_acc && paddr == addr_entry2;
  assign entry_wr[3] = wr_acc && paddr == addr_entry3;

  // Analog limit: (input - offset) in volts times gain percent per volt
  always_comb begin
    offset_mv   = auto_offset_enable_r ? auto_offset_mv_r : analog_limit_offset_volts_r;
    net_mv      = (analog_in_mv > offset_mv) ? 16'(analog_in_mv - offset_mv) : 16'h0000;
    analog_prod = (32'(net_mv) * 32'(analog_limit_gain_r)) / 32'(mv_per_volt);
    analog_pct  = (analog_prod > 32'(torque_max_pct)) ? torque_max_pct : analog_prod[8:0];
  end

  // Inputs sampled every cycle; the chosen limit applies from the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r      <= 2'b00;
      limit_en_r <= 1'b0;
    end else begin
      sel_r      <= {data_select_high, data_select_low};
      limit_en_r <= torque_limit_enable;
    end
  end

  always_comb begin
    if (sel_r == 2'b00 && analog_input_option_r) begin
      limit_nxt = analog_pct;
    end else begin
      limit_nxt = entry_val[sel_r];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_r <= torque_max_pct;
    end else begin
      limit_r <= limit_en_r ? limit_nxt : torque_max_pct;
    end
  end

  // Torque cap; a zero limit gives zero torque whatever the demand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_cmd_pct     <= 9'd0;
      limit_reached_flag <= 1'b0;
    end else begin
      torque_cmd_pct     <= (torque_demand_pct > limit_r) ? limit_r : torque_demand_pct;
      limit_reached_flag <= limit_en_r && (torque_demand_pct >= limit_r);
    end
  end

  assign active_limit_pct = limit_r;

  // Revolution count rebuilt from a retained position so the revolution bound still holds
  // Floor division keeps a negative position's fraction in 0 to pulses_per_rev-1
  always_comb begin
    boot_rev  = $signed(retained_pos) / $signed({16'h0000, pulses_per_rev});
    boot_frac = $signed(retained_pos) % $signed({16'h0000, pulses_per_rev});
    if ($signed(boot_frac) < 0) begin
      boot_rev  = boot_rev - 32'h0000_0001;
      boot_frac = boot_frac + {16'h0000, pulses_per_rev};
    end
  end

  // Command position keeps counting pulses even with zero torque allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r       <= 32'h0000_0000;
      rev_r       <= 32'h0000_0000;
      rev_frac_r  <= 16'h0000;
      range_err_r <= 1'b0;
    end else if (boot_r == boot_capture) begin
      // Retained position only with absolute on and battery present
      if (absolute_function_switch && battery_present && retained_valid) begin
        pos_r      <= retained_pos;
        rev_r      <= boot_rev;
        rev_frac_r <= boot_frac[15:0];
      end else begin
        pos_r      <= 32'h0000_0000;
        rev_r      <= 32'h0000_0000;
        rev_frac_r <= 16'h0000;
      end
    end else if (pulse_step && !range_err_r) begin
      if (pulse_dir_neg) begin
        if (pos_r == 32'h8000_0000 || ($signed(rev_r) <= 32'(rev_min) && rev_frac_r == 16'h0000)) begin
          range_err_r <= 1'b1;
        end else begin
          pos_r <= pos_r - 32'h0000_0001;
          if (rev_frac_r == 16'h0000) begin
            rev_frac_r <= pulses_per_rev - 16'h0001;
            rev_r      <= rev_r - 32'h0000_0001;
          end else begin
            rev_frac_r <= rev_frac_r - 16'h0001;
          end
        end
      end else begin
        if (pos_r == 32'h7fff_ffff ||
            ($signed(rev_r) >= 32'(rev_max) && rev_frac_r >= pulses_per_rev - 16'h0001)) begin
          range_err_r <= 1'b1;
        end else begin
          pos_r <= pos_r + 32'h0000_0001;
          if (rev_frac_r >= pulses_per_rev - 16'h0001) begin
            rev_frac_r <= 16'h0000;
            rev_r      <= rev_r + 32'h0000_0001;
          end else begin
            rev_frac_r <= rev_frac_r + 16'h0001;
          end
        end
      end
    end
  end

  assign command_pos        = pos_r;
  assign absolute_enabled   = abs_en_r;
  assign position_retain_en = abs_en_r && battery_present;

  // Alarm causes evaluated once settings are latched
  always_comb begin
    alarm_set = '0;
    if (boot_r != boot_capture) begin
      alarm_set[alm_no_batt_bit]   = abs_en_r && !battery_present;
      alarm_set[alm_abs_unsup_bit] = !abs_en_r && battery_present;
      alarm_set[alm_pos_loss_bit]  = abs_en_r && (
                                     (boot_r == boot_check && !retained_valid) ||
                                     battery_low || !encoder_connected ||
                                     (alarm_r[alm_range_bit] && motor_run_request));
      alarm_set[alm_range_bit]     = range_err_r;
    end
  end

  // Sticky alarms; a cause present in the clearing cycle keeps its bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_r <= '0;
    end else if (wr_acc && paddr == addr_alarm_clr) begin
      alarm_r <= (alarm_r & ~wdata_lim[alarm_width-1:0]) | alarm_set;
    end else begin
      alarm_r <= alarm_r | alarm_set;
    end
  end

  assign alarm_flags = alarm_r;

  // Read data registered on the setup cycle so it holds through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        addr_ctrl:     prdata <= {31'h0, auto_offset_enable_r};
        addr_gain:     prdata <= {23'h0, analog_limit_gain_r};
        addr_offset:   prdata <= {16'h0, analog_limit_offset_volts_r};
        addr_entry0:   prdata <= {23'h0, entry_val[0]};
        addr_entry1:   prdata <= {23'h0, entry_val[1]};
        addr_entry2:   prdata <= {23'h0, entry_val[2]};
        addr_entry3:   prdata <= {23'h0, entry_val[3]};
        addr_cfg_next: prdata <= {30'h0, absolute_function_switch, cfg_analog_r};
        addr_status:   prdata <= {26'h0, range_err_r, limit_reached_flag, limit_en_r,
                                  abs_en_r, analog_input_option_r, sel_r != 2'b00};
        addr_alarm:    prdata <= {28'h0, alarm_r};
        addr_cmd_pos:  prdata <= pos_r;
        addr_limit:    prdata <= {23'h0, limit_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

//--- shared/servo_limit_pkg.sv
// Package: register map, field layouts, reset values and limits of the servo limit block
package servo_limit_pkg;
  localparam logic [7:0] addr_ctrl      = 8'h00;
  localparam logic [7:0] addr_gain      = 8'h04;
  localparam logic [7:0] addr_offset    = 8'h08;
  localparam logic [7:0] addr_entry1    = 8'h0c;
  localparam logic [7:0] addr_entry2    = 8'h10;
  localparam logic [7:0] addr_entry3    = 8'h14;
  localparam logic [7:0] addr_entry0    = 8'h18;
  localparam logic [7:0] addr_cfg_next  = 8'h1c;
  localparam logic [7:0] addr_status    = 8'h20;
  localparam logic [7:0] addr_alarm     = 8'h24;
  localparam logic [7:0] addr_alarm_clr = 8'h28;
  localparam logic [7:0] addr_cmd_pos   = 8'h2c;
  localparam logic [7:0] addr_limit     = 8'h30;
  // Control register fields
  localparam int ctrl_auto_offset_bit = 0;
  localparam int ctrl_capture_bit     = 1;
  // Pending system settings fields
  localparam int cfg_analog_bit       = 0;
  localparam int cfg_abs_bit          = 1;
  // Alarm fields
  localparam int alm_no_batt_bit      = 0;
  localparam int alm_abs_unsup_bit    = 1;
  localparam int alm_pos_loss_bit     = 2;
  localparam int alm_range_bit        = 3;
  localparam int alarm_width          = 4;
  // Torque in percent of rated, millivolts for analog input
  localparam logic [8:0]  torque_max_pct    = 9'd300;
  localparam logic [8:0]  gain_max_pct      = 9'd300;
  localparam logic [8:0]  gain_reset_pct    = 9'd30;
  localparam logic [15:0] offset_reset_mv   = 16'h0000;
  localparam logic [8:0]  entry_reset_pct   = 9'd300;
  localparam logic        analog_reset      = 1'b1;
  localparam logic        abs_reset         = 1'b0;
  localparam int          mv_per_volt       = 1000;
  // Revolution range bounds on the position counter
  localparam logic signed [15:0] rev_min    = 16'sh8000;
  localparam logic signed [15:0] rev_max    = 16'sh7fff;
endpackage

//--- hw/torque_entry_reg.sv
// One software-written torque-limit entry, clamped to the maximum torque
module torque_entry_reg
  import servo_limit_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [8:0] wr_data,
  output logic      [8:0] value_r
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= entry_reset_pct;
    end else if (wr_en) begin
      value_r <= (wr_data > torque_max_pct) ? torque_max_pct : wr_data;
    end
  end
endmodule

//--- verification/ctrl_model.sv
// Controller model: drives the data selects, limit enable and command pulses
module ctrl_model (
  input  wire logic       pclk,
  input  wire logic [1:0] code_req,
  input  wire logic       en_req,
  input  wire logic       step_req,
  output logic            data_select_low,
  output logic            data_select_high,
  output logic            torque_limit_enable,
  output logic            pulse_step
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {data_select_low, data_select_high, torque_limit_enable, pulse_step} = 4'h0;
  always @(posedge pclk) begin
    data_select_low     <= code_req[0];
    data_select_high    <= code_req[1];
    torque_limit_enable <= en_req;
    // Gap after each pulse so every pulse stands one cycle only
    pulse_step          <= step_req && !pulse_step;
  end
endmodule

//--- verification/servo_limit_assertions.sv
// Checker: port-level properties of the servo limit block
module servo_limit_assertions
  import servo_limit_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   torque_limit_enable,
  input wire logic                   battery_present,
  input wire logic                   encoder_connected,
  input wire logic                   motor_run_request,
  input wire logic [8:0]             torque_cmd_pct,
  input wire logic [8:0]             active_limit_pct,
  input wire logic                   limit_reached_flag,
  input wire logic                   position_retain_en,
  input wire logic                   absolute_enabled,
  input wire logic [alarm_width-1:0] alarm_flags
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  limit_off_max_a: assert property (!torque_limit_enable |-> ##2
    active_limit_pct == torque_max_pct) else $error("limit not at maximum");
  torque_cap_a: assert property (torque_cmd_pct <= $past(active_limit_pct))
    else $error("torque above limit");
  flag_match_a: assert property (limit_reached_flag ==
    ($past(torque_limit_enable, 2) && torque_cmd_pct == $past(active_limit_pct)))
    else $error("limit flag wrong");
  retain_en_a: assert property (position_retain_en ==
    (absolute_enabled && battery_present)) else $error("retain enable wrong");
  abs_frozen_a: assert property ($past(presetn, 2) |-> $stable(absolute_enabled))
    else $error("absolute enable changed without reset");
  no_batt_a: assert property ($past(presetn, 2) && absolute_enabled && !battery_present
    |-> ##[1:2] alarm_flags[alm_no_batt_bit]) else $error("no battery alarm missing");
  abs_unsup_a: assert property ($past(presetn, 2) && !absolute_enabled
    && battery_present |-> ##[1:2] alarm_flags[alm_abs_unsup_bit])
    else $error("not supported alarm missing");
  range_loss_a: assert property (alarm_flags[alm_range_bit] && motor_run_request
    |-> ##[1:2] alarm_flags[alm_pos_loss_bit]) else $error("loss after range missing");
  cable_loss_a: assert property ($past(presetn, 2) && absolute_enabled
    && !encoder_connected |-> ##[1:2] alarm_flags[alm_pos_loss_bit])
    else $error("cable loss alarm missing");
endmodule
bind servo_limit servo_limit_assertions servo_limit_assertions_inst (
  .pclk(pclk), .presetn(presetn), .torque_limit_enable(torque_limit_enable),
  .battery_present(battery_present), .encoder_connected(encoder_connected),
  .motor_run_request(motor_run_request), .torque_cmd_pct(torque_cmd_pct),
  .active_limit_pct(active_limit_pct), .limit_reached_flag(limit_reached_flag),
  .position_retain_en(position_retain_en), .absolute_enabled(absolute_enabled),
  .alarm_flags(alarm_flags));

//--- verification/tb_top.sv
// Testbench: torque limit selection and absolute position supervision scenarios
module tb_top
  import servo_limit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, retained_pos = 32'h0, prdata, command_pos;
  logic [15:0] analog_in_mv = 16'h0, pulses_per_rev = 16'h1;
  logic [8:0]  torque_demand_pct = 9'h0, torque_cmd_pct, active_limit_pct;
  logic        pulse_dir_neg = 1'b0, battery_present = 1'b0, battery_low = 1'b0;
  logic        encoder_connected = 1'b1, retained_valid = 1'b0, absolute_function_switch = 1'b0;
  logic        motor_run_request = 1'b0, en_req = 1'b0, step_req = 1'b0;
  logic [1:0]  code_req = 2'h0;
  logic        pready, pslverr, data_select_low, data_select_high, torque_limit_enable;
  logic        pulse_step, limit_reached_flag, position_retain_en, absolute_enabled;
  logic [alarm_width-1:0] alarm_flags;
  int          bad_count = 0, comparisons = 0;
  always #5 pclk = ~pclk;
  ctrl_model ctrl_model_inst (.*);
  servo_limit servo_limit_inst (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rst;
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(6);
    presetn <= 1'b1;
    cyc(4);
  endtask
  task automatic pulses(input int n, input logic neg);
    pulse_dir_neg <= neg;
    step_req <= 1'b1;
    cyc(2 * n);
    step_req <= 1'b0;
    cyc(4);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(addr_gain, 32'(gain_reset_pct));
    rd(addr_entry1, 32'(entry_reset_pct));
    rd(addr_cfg_next, 32'h1);
    wr(addr_gain, 32'h190);
    rd(addr_gain, 32'(gain_max_pct));
    wr(addr_gain, 32'h1e);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    rd(addr_limit, 32'(torque_max_pct));
  endtask
  task automatic t_select;
    logic [8:0] lim [4];
    lim = '{9'h3c, 9'ha, 9'h14, 9'h1e};
    wr(addr_entry1, 32'ha);
    wr(addr_entry2, 32'h14);
    wr(addr_entry3, 32'h1e);
    analog_in_mv <= 16'h7d0;
    en_req <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      code_req <= 2'(i);
      cyc(6);
      chk(32'(active_limit_pct), 32'(lim[i]));
    end
    code_req <= 2'h0;
    wr(addr_offset, 32'h3e8);
    cyc(6);
    chk(32'(active_limit_pct), 32'h1e);
    analog_in_mv <= 16'h1f4;
    cyc(2);
    wr(addr_ctrl, 32'h3);
    analog_in_mv <= 16'h7d0;
    cyc(6);
    chk(32'(active_limit_pct), 32'h2d);
    wr(addr_ctrl, 32'h0);
    wr(addr_offset, 32'h0);
    en_req <= 1'b0;
    cyc(5);
    chk(32'(active_limit_pct), 32'(torque_max_pct));
  endtask
  task automatic t_zero;
    torque_demand_pct <= 9'h32;
    code_req <= 2'h2;
    en_req <= 1'b1;
    cyc(6);
    chk(32'(torque_cmd_pct), 32'h14);
    chk(32'(limit_reached_flag), 32'h1);
    wr(addr_entry1, 32'h0);
    code_req <= 2'h1;
    cyc(6);
    chk(32'(torque_cmd_pct), 32'h0);
    pulses(5, 1'b0);
    pulses(2, 1'b1);
    chk(command_pos, 32'h3);
    en_req <= 1'b0;
    cyc(6);
    chk(32'(torque_cmd_pct), 32'h32);
    chk(32'(limit_reached_flag), 32'h0);
  endtask
  task automatic t_sysset;
    wr(addr_cfg_next, 32'h0);
    code_req <= 2'h0;
    en_req <= 1'b1;
    cyc(6);
    chk(32'(active_limit_pct), 32'h3c);
    rst;
    wr(addr_entry0, 32'h28);
    cyc(6);
    chk(32'(active_limit_pct), 32'h28);
    en_req <= 1'b0;
  endtask
  task automatic t_abs;
    absolute_function_switch <= 1'b1;
    battery_present <= 1'b1;
    retained_valid <= 1'b1;
    retained_pos <= 32'h7ffd;
    rst;
    chk(32'(absolute_enabled), 32'h1);
    chk(command_pos, 32'h7ffd);
    chk(32'(alarm_flags), 32'h0);
    pulses(4, 1'b0);
    chk(32'(alarm_flags), 32'h8);
    chk(command_pos, 32'h7fff);
    motor_run_request <= 1'b1;
    cyc(3);
    chk(32'(alarm_flags[alm_pos_loss_bit]), 32'h1);
    motor_run_request <= 1'b0;
    absolute_function_switch <= 1'b0;
    wr(addr_alarm_clr, 32'hf);
    encoder_connected <= 1'b0;
    cyc(3);
    chk(32'(alarm_flags), 32'hc);
    chk(32'(absolute_enabled), 32'h1);
    encoder_connected <= 1'b1;
    battery_present <= 1'b0;
    cyc(3);
    chk(32'(alarm_flags[alm_no_batt_bit]), 32'h1);
    battery_present <= 1'b1;
    rst;
    chk(32'(absolute_enabled), 32'h0);
    chk(command_pos, 32'h0);
    chk(32'(alarm_flags), 32'h2);
    absolute_function_switch <= 1'b1;
    retained_valid <= 1'b0;
    rst;
    chk(32'(alarm_flags), 32'h4);
    chk(32'(position_retain_en), 32'h1);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    rst;
    t_regs;
    t_select;
    t_zero;
    t_sysset;
    t_abs;
    print_verdict;
  end
  // Whole run is a few hundred cycles, so this limit only trips on a hang
  initial begin
    #200000;
    bad_count++;
    print_verdict;
  end
endmodule
